//--- cfm_device.sv
// device end: configuration and management register port
`timescale 1ns/1ps
`default_nettype none
module cfm_device
    import cfm_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // mode strap: high for root port
    input  wire logic root_port_i,
    // link side
    cfm_if.dev        bus
);
    import cfm_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0]
    {
        CFM_IDLE = 3'b001,
        CFM_BUSY = 3'b010,
        CFM_DONE = 3'b100
    } cfm_state_e;

    // the whole state in one record: one comb fill, one register
    typedef struct packed
    {
        cfm_state_e                       state;
        logic [3:0]                       cnt;
        cfm_data_t                        rdata;
        logic [NUM_FUNC*CFG_WORDS-1:0][DATA_W-1:0] cfg;
        logic [MGMT_WORDS-1:0][DATA_W-1:0] mgmt;
        // strap synchroniser
        logic [1:0]                       root_sync;
    } cfm_dev_s;

    cfm_dev_s st_r;
    cfm_dev_s st_nxt;

    // ****************************************
    // decode
    // ****************************************
    // merge new data into a stored word, lane by lane
    function automatic cfm_data_t merge_word(input cfm_data_t old_w,
                                             input cfm_data_t new_w,
                                             input cfm_data_t mask);
        return (old_w & ~mask) | (new_w & mask);
    endfunction

    // register field inside a window of mapped words
    function automatic logic in_window(input logic [REG_W-1:0] sel,
                                       input int               words);
        return (int'(sel) < words);
    endfunction

    // decoded fields of the address now on the link
    logic [REG_W-1:0]  reg_sel;
    logic [FUNC_W-1:0] func_sel;
    logic              is_mgmt;
    logic              cfg_hit;
    logic              mgmt_hit;
    logic [IDX_W:0]    cfg_idx;
    logic [IDX_W-1:0]  mgmt_idx;
    cfm_data_t         wmask;
    cfm_data_t         eff_mask;
    cfm_data_t         rd_word;
    logic              root_port;
    logic              ovr_ok;

    // ****************************************
    // lane mask
    // ****************************************
    // one lane per byte enable bit; no partial lanes exist
    for (genvar gi = 0; gi < BE_W; gi++)
    begin : g_lane
        assign wmask[gi*8 +: 8] = {8{bus.byte_enable[gi]}};
    end

    // ****************************************
    // address decode
    // ****************************************
    always_comb
    begin
        root_port = st_r.root_sync[1];
        reg_sel   = bus.addr[REG_LSB +: REG_W];
        func_sel  = bus.addr[FUNC_LSB +: FUNC_W];
        is_mgmt   = bus.addr[SPACE_BIT];
        // function field is ignored in the management space
        mgmt_hit  = is_mgmt && in_window(reg_sel, MGMT_WORDS);
        cfg_hit   = !is_mgmt && (int'(func_sel) < NUM_FUNC)
                  && in_window(reg_sel, CFG_WORDS);
        // two functions only, so one function bit picks the bank
        cfg_idx   = {func_sel[0], reg_sel[IDX_W-1:0]};
        mgmt_idx  = reg_sel[IDX_W-1:0];
        // override counts only in root port mode on type-1 header words
        ovr_ok    = root_port && bus.readonly_field_override
                  && !is_mgmt
                  && in_window(reg_sel, TYPE1_HDR_WORDS);
        eff_mask  = ovr_ok ? wmask : (wmask & ~RO_MASK);
    end

    // ****************************************
    // read mux
    // ****************************************
    // unmapped reads give zero, never a stale or aliased word
    // rd_word is taken only on the last busy cycle
    always_comb
    begin
        rd_word = DATA_RST;
        if (mgmt_hit)
        begin
            rd_word = st_r.mgmt[mgmt_idx];
        end
        else if (cfg_hit)
        begin
            rd_word = st_r.cfg[cfg_idx];
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        // strap comes in from a pin: two flops, only the second is read
        st_nxt.root_sync = {st_r.root_sync[0], root_port_i};

        unique case (st_r.state)
            CFM_IDLE:
            begin
                // a request is taken only from idle
                if (bus.read || bus.write)
                begin
                    st_nxt.state = CFM_BUSY;
                    st_nxt.cnt   = ACCESS_LAT;
                end
            end
            CFM_BUSY:
            begin
                // strobes are not looked at again until the last busy
                // cycle; the fixed wait keeps the done timing simple
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1)
                begin
                    st_nxt.state = CFM_DONE;
                    // a write to an unmapped word is dropped
                    if (bus.write && mgmt_hit)
                    begin
                        // management words have no read-only bits
                        st_nxt.mgmt[mgmt_idx] =
                            merge_word(st_r.mgmt[mgmt_idx],
                                       bus.write_data, wmask);
                    end
                    if (bus.write && cfg_hit)
                    begin
                        st_nxt.cfg[cfg_idx] =
                            merge_word(st_r.cfg[cfg_idx],
                                       bus.write_data, eff_mask);
                    end
                    if (bus.read)
                    begin
                        st_nxt.rdata = rd_word;
                    end
                end
            end
            CFM_DONE:
            begin
                // one cycle only, then back to idle
                st_nxt.state = CFM_IDLE;
            end
            default:
            begin
                // a corrupted one-hot code falls back to idle
                st_nxt.state = CFM_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    // reset clears every stored word to zero
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r       <= '0;
            st_r.state <= CFM_IDLE;
            st_r.rdata <= DATA_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // read data holds until the next read completes
    assign bus.read_data = st_r.rdata;
    // done decodes the state, so it cannot stretch
    assign bus.done      = (st_r.state == CFM_DONE);
endmodule
`default_nettype wire

//--- cfm_pkg.sv
// constants and types shared by both ends of the config access port
// Operation
// - dword aligned address, bits 9:0 pick register
// - address bits 17:10 pick the function
// - bit 18 low config, high management
// - requester raises write strobe to write
// - 32-bit data, byte enable 0 covers 7:0
// - requester raises read strobe to read
// - device returns addressed register on read data
// - done pulse lasts exactly one cycle
// - root port override writes type-1 read-only fields
// - override ignored for endpoint or other registers
`default_nettype none
package cfm_pkg;
    localparam int ADDR_W     = 19;
    localparam int DATA_W     = 32;
    localparam int BE_W       = 4;
    localparam int REG_LSB    = 0;
    localparam int REG_W      = 10;
    localparam int FUNC_LSB   = 10;
    localparam int FUNC_W     = 8;
    localparam int SPACE_BIT  = 18;
    localparam int NUM_FUNC   = 2;
    localparam int CFG_WORDS  = 16;
    localparam int MGMT_WORDS = 16;
    localparam int IDX_W      = 4;
    localparam int TYPE1_HDR_WORDS = 16;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    // mask of read-only bits in a type-1 header word, arbitrary placement
    localparam logic [DATA_W-1:0] RO_MASK  = 32'hffff_0000;
    localparam logic [3:0]        ACCESS_LAT = 4'h2;

    typedef logic [ADDR_W-1:0] cfm_addr_t;
    typedef logic [DATA_W-1:0] cfm_data_t;
    typedef logic [BE_W-1:0]   cfm_be_t;
endpackage
`default_nettype wire

//--- cfm_if.sv
// interface joining the config requester to the config port
`timescale 1ns/1ps
`default_nettype none
interface cfm_if;
    import cfm_pkg::*;
    cfm_addr_t addr;
    logic      write;
    cfm_data_t write_data;
    cfm_be_t   byte_enable;
    logic      read;
    cfm_data_t read_data;
    logic      done;
    logic      readonly_field_override;

    modport dev
    (
        input  addr, write, write_data, byte_enable, read,
        input  readonly_field_override,
        output read_data, done
    );
    modport req
    (
        output addr, write, write_data, byte_enable, read,
        output readonly_field_override,
        input  read_data, done
    );
endinterface
`default_nettype wire

//--- cfm_requester.sv
// requester end: user logic driving the config access port
`timescale 1ns/1ps
`default_nettype none
module cfm_requester
    import cfm_pkg::*;
(
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    // user request
    input  wire logic     req_valid_i,
    input  wire logic     req_write_i,
    input  wire logic     req_mgmt_i,
    input  wire logic [FUNC_W-1:0] req_func_i,
    input  wire logic [REG_W-1:0]  req_reg_i,
    input  wire cfm_pkg::cfm_data_t req_wdata_i,
    input  wire cfm_pkg::cfm_be_t   req_be_i,
    input  wire logic     req_override_i,
    output logic          req_ready_o,
    // user answer
    output logic          rsp_valid_o,
    output cfm_pkg::cfm_data_t rsp_rdata_o,
    // link side
    cfm_if.req            bus
);
    import cfm_pkg::*;

    typedef enum logic [1:0]
    {
        CFR_IDLE = 2'b01,
        CFR_WAIT = 2'b10
    } cfr_state_e;

    typedef struct packed
    {
        cfr_state_e state;
        logic       write;
        logic       read;
        logic       ovr;
        cfm_addr_t  addr;
        cfm_data_t  wdata;
        cfm_be_t    be;
        logic       rsp_valid;
        cfm_data_t  rdata;
    } cfr_s;

    cfr_s st_r;
    cfr_s st_nxt;

    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.rsp_valid = 1'b0;
        unique case (st_r.state)
            CFR_IDLE:
            begin
                if (req_valid_i)
                begin
                    st_nxt.state = CFR_WAIT;
                    st_nxt.addr  = {req_mgmt_i, req_func_i, req_reg_i};
                    st_nxt.write = req_write_i;
                    st_nxt.read  = !req_write_i;
                    st_nxt.wdata = req_wdata_i;
                    st_nxt.be    = req_be_i;
                    st_nxt.ovr   = req_override_i && req_write_i;
                end
            end
            CFR_WAIT:
            begin
                // request held steady until the done pulse
                if (bus.done)
                begin
                    st_nxt.state     = CFR_IDLE;
                    st_nxt.write     = 1'b0;
                    st_nxt.read      = 1'b0;
                    st_nxt.ovr       = 1'b0;
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.rdata     = bus.read_data;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r       <= '0;
            st_r.state <= CFR_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign req_ready_o             = (st_r.state == CFR_IDLE);
    assign rsp_valid_o             = st_r.rsp_valid;
    assign rsp_rdata_o             = st_r.rdata;
    assign bus.addr                = st_r.addr;
    assign bus.write               = st_r.write;
    assign bus.read                = st_r.read;
    assign bus.write_data          = st_r.wdata;
    assign bus.byte_enable         = st_r.be;
    assign bus.readonly_field_override = st_r.ovr;
endmodule
`default_nettype wire

//--- cfm_chk.sv
// assertions on the link between requester and device ends
`timescale 1ns/1ps
`default_nettype none
module cfm_chk
    import cfm_pkg::*;
(
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    // link signals
    input wire cfm_pkg::cfm_addr_t addr,
    input wire logic               write,
    input wire cfm_pkg::cfm_data_t write_data,
    input wire cfm_pkg::cfm_be_t   byte_enable,
    input wire logic               read,
    input wire cfm_pkg::cfm_data_t read_data,
    input wire logic               done,
    input wire logic               readonly_field_override
);
    import cfm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_done_one_cycle: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_done_fixed_lat: assert property ($rose(read || write)
        |-> !done [*3] ##1 done) else $error("done latency wrong");
    a_done_has_req: assert property (done |-> read || write)
        else $error("done without request");
    a_one_strobe: assert property (!(read && write))
        else $error("read and write together");
    a_req_held: assert property ((read || write) && !done
        |=> $stable({addr, write_data, byte_enable, read, write,
        readonly_field_override})) else $error("request moved");
    a_drop_on_done: assert property (done |=> !read && !write)
        else $error("strobe kept after done");
    a_rdata_on_done: assert property ($changed(read_data)
        |-> done && read) else $error("read data moved alone");
    a_read_no_ovr: assert property (read
        |-> !readonly_field_override) else $error("override on read");

    c_read: cover property (done && read);
    c_ovr_write: cover property (done && write && readonly_field_override);
    c_mgmt: cover property (done && addr[SPACE_BIT]);
endmodule
`default_nettype wire

//--- config_space_mgmt_port_bench.sv
// bench joining requester and device ends across the link
`timescale 1ns/1ps
`default_nettype none
module config_space_mgmt_port_bench;
    import cfm_pkg::*;
    logic              clk_i, rst_n_i, root_port;
    logic              v, w, m, o, rdy, rsp, s;
    logic [FUNC_W-1:0] f;
    logic [REG_W-1:0]  r;
    cfm_data_t         d, q, rdata;
    cfm_be_t           b;
    int                fails, checked;
    cfm_if bus ();

    cfm_device i_cfm_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .root_port_i(root_port), .bus(bus));
    cfm_requester i_cfm_requester (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(v), .req_write_i(w), .req_mgmt_i(m), .req_func_i(f),
        .req_reg_i(r), .req_wdata_i(d), .req_be_i(b), .req_override_i(o),
        .req_ready_o(rdy), .rsp_valid_o(rsp), .rsp_rdata_o(rdata),
        .bus(bus));
    cfm_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(bus.addr),
        .write(bus.write), .write_data(bus.write_data),
        .byte_enable(bus.byte_enable), .read(bus.read),
        .read_data(bus.read_data), .done(bus.done),
        .readonly_field_override(bus.readonly_field_override));

    task automatic cmp(input string n, input cfm_data_t e, g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // one whole transfer; strobe kind and address taken off the link
    task automatic xfer(input logic iw, im, input int fi, ri,
                        input cfm_data_t id, input cfm_be_t ib,
                        input logic io);
        int        n;
        cfm_addr_t a;
        @(negedge clk_i);
        cmp("ready", 32'h1, 32'(rdy));
        cmp("rsp_low", 32'h0, 32'(rsp));
        {v, w, m, o, d, b} = {1'b1, iw, im, io, id, ib};
        f = fi[FUNC_W-1:0];
        r = ri[REG_W-1:0];
        @(negedge clk_i);
        v = 1'b0;
        cmp("busy", 32'h0, 32'(rdy));
        a = '0;
        s = 1'b0;
        for (n = 0; n < 20 && rsp !== 1'b1; n++)
        begin
            @(negedge clk_i);
            if (bus.read || bus.write)
                {a, s} = {bus.addr, bus.write};
        end
        cmp("addr", 32'({im, f, r}), 32'(a));
        cmp("kind", 32'(iw), 32'(s));
        cmp("rsp", 32'h1, 32'(rsp));
        q = rdata;
    endtask

    task automatic wr(input logic mm, input int fi, ri,
                      input cfm_data_t id, input cfm_be_t ib, input logic io);
        xfer(1'b1, mm, fi, ri, id, ib, io);
    endtask

    task automatic rd(input logic mm, input int fi, ri, input cfm_data_t e);
        xfer(1'b0, mm, fi, ri, '0, '0, 1'b0);
        cmp("rdata", e, q);
    endtask

    task automatic t_reset_vals;
        rd(1'b0, 0, 0, DATA_RST);
        rd(1'b1, 0, 15, DATA_RST);
    endtask

    // read-only upper half survives; lanes follow their enables
    task automatic t_bytes;
        wr(1'b0, 1, 3, 32'ha5c3_1234, 4'hf, 1'b0);
        rd(1'b0, 1, 3, 32'ha5c3_1234 & ~RO_MASK);
        wr(1'b0, 1, 3, 32'h0000_00ff, 4'h1, 1'b0);
        rd(1'b0, 1, 3, 32'h0000_12ff);
        wr(1'b0, 1, 3, 32'h0000_5677, 4'h2, 1'b0);
        rd(1'b0, 1, 3, 32'h0000_56ff);
    endtask

    task automatic t_space;
        wr(1'b1, 0, 3, 32'h1357_9bdf, 4'hf, 1'b0);
        rd(1'b1, 0, 3, 32'h1357_9bdf);
        rd(1'b0, 0, 3, DATA_RST);
        rd(1'b0, 1, 3, 32'h0000_56ff);
    endtask

    task automatic t_override;
        wr(1'b0, 0, 2, 32'hdead_beef, 4'hf, 1'b1);
        rd(1'b0, 0, 2, 32'h0000_beef);
        root_port = 1'b1;
        wr(1'b0, 0, 2, 32'hdead_beef, 4'hf, 1'b1);
        rd(1'b0, 0, 2, 32'hdead_beef);
        wr(1'b0, 0, 2, 32'h1111_2222, 4'hf, 1'b0);
        rd(1'b0, 0, 2, 32'hdead_2222);
    endtask

    task automatic t_unmapped;
        wr(1'b0, NUM_FUNC, 1, 32'h5a5a_5a5a, 4'hf, 1'b0);
        rd(1'b0, NUM_FUNC, 1, 32'h0);
        rd(1'b0, 0, 1, 32'h0);
        rd(1'b0, 0, CFG_WORDS, 32'h0);
    endtask

    task automatic test_done;
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // a hang costs a mismatch; a full run needs about 150 cycles
    initial
    begin
        repeat (3000) @(posedge clk_i);
        fails++;
        test_done;
    end

    initial
    begin
        {rst_n_i, root_port, v, w, m, o, f, r, d, b} = '0;
        fails = 0;
        checked = 0;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset_vals;
        t_bytes;
        t_space;
        t_override;
        t_unmapped;
        test_done;
    end
endmodule
`default_nettype wire
